/* cth_defs.vh */
// Function
// - after busy low, processor reads memory words and presents them on bus
// - cache-hit words go to the coprocessor at the fast core clock rate
// - coprocessor clock withheld while first word fetched, delivered next cycle
// - processor reads one extra word when loading coprocessor and discards it
// - address computed once in the start cycle, base written back during transfer
// - storing to memory, processor lags coprocessor one cycle per word
// - at store start processor stalls one cycle while first word appears
// - at store end coprocessor clock stopped while last write waits for mem_ack_i (not at all if acked at once)
// - capable but unready coprocessor: absent low, busy high; processor waits
// - processor busy-waits three cycles in the catch phase before judging the lines
// - both lines high at evaluation means undefined instruction trap
`ifndef CTH_DEFS_VH
`define CTH_DEFS_VH
`define CTH_ST_IDLE    3'h0
`define CTH_ST_CATCH   3'h1
`define CTH_ST_WAIT    3'h2
`define CTH_ST_LDXFER  3'h3
`define CTH_ST_STSTALL 3'h4
`define CTH_ST_STXFER  3'h5
`define CTH_ST_STLAST  3'h6
`define CTH_ST_DONE    3'h7
`define CTH_OP_CDO     2'h0
`define CTH_OP_LOAD    2'h1
`define CTH_OP_STORE   2'h2
`define CTH_WORD_STEP  32'h00000004
`define CTH_CATCH_CYC  2'h2
`endif

/* cth_sync2.v */
`timescale 1ns/1ps
module cth_sync2 #(
   parameter RESET_VAL = 1'b1
) (
   input  wire ref_clk_i,
   input  wire rstn_i,
   input  wire d_i,
   output wire q_o
);
   reg meta_q;
   reg sync_q;
   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_q <= RESET_VAL[0];
         sync_q <= RESET_VAL[0];
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end
   assign q_o = sync_q;
endmodule // cth_sync2

/* cth_handshake.v */
`timescale 1ns/1ps
`include "cth_defs.vh"
module cth_handshake #(
   parameter DW = 32
) (
   input  wire          ref_clk_i,
   input  wire          rstn_i,
   input  wire          start_i,
   input  wire [1:0]    op_i,
   input  wire [31:0]   base_addr_i,
   input  wire [31:0]   offset_i,
   input  wire          cache_hit_i,
   input  wire          mem_ack_i,
   input  wire [DW-1:0] mem_rdata_i,
   input  wire          coproc_absent_line_i,
   input  wire          coproc_busy_line_i,
   input  wire [DW-1:0] coproc_data_bus_i,
   output reg           coproc_instr_strobe_n_o,
   output reg           coproc_clk_en_o,
   output reg  [DW-1:0] coproc_data_bus_o,
   output reg           coproc_data_bus_oe_o,
   output reg           mem_req_o,
   output reg           mem_write_o,
   output reg           mem_seq_o,
   output reg  [31:0]   mem_addr_o,
   output reg  [DW-1:0] mem_wdata_o,
   output reg           fast_core_clock_sel_o,
   output reg           base_wb_o,
   output reg  [31:0]   base_wb_data_o,
   output reg           undef_trap_o,
   output reg           fetch_nonseq_o,
   output reg           done_o
);
   wire cpa_s;
   wire cpb_s;
   cth_sync2 u_sync_a (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
                       .d_i(coproc_absent_line_i), .q_o(cpa_s));
   cth_sync2 u_sync_b (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
                       .d_i(coproc_busy_line_i), .q_o(cpb_s));
   reg [2:0]    state_q;
   reg [1:0]    op_q;
   reg [31:0]   addr_q;
   reg [1:0]    catch_q;
   reg          first_q;
   // coprocessor runs off this clock through the enable: raw lines end a transfer
   // with no lag, the synchronised pair only serves the wait-phase decision
   wire         last_seen = coproc_absent_line_i & coproc_busy_line_i;
   function [31:0] next_word;
      input [31:0] a;
      begin
         next_word = a + `CTH_WORD_STEP;
      end
   endfunction
   ////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= `CTH_ST_IDLE;
         op_q <= `CTH_OP_CDO;
         addr_q <= 32'h00000000;
         catch_q <= 2'h0;
         first_q <= 1'b0;
         coproc_instr_strobe_n_o <= 1'b1;
         coproc_clk_en_o <= 1'b1;
         coproc_data_bus_o <= {DW{1'b0}};
         coproc_data_bus_oe_o <= 1'b0;
         mem_req_o <= 1'b0;
         mem_write_o <= 1'b0;
         mem_seq_o <= 1'b0;
         mem_addr_o <= 32'h00000000;
         mem_wdata_o <= {DW{1'b0}};
         fast_core_clock_sel_o <= 1'b0;
         base_wb_o <= 1'b0;
         base_wb_data_o <= 32'h00000000;
         undef_trap_o <= 1'b0;
         fetch_nonseq_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         base_wb_o <= 1'b0;
         undef_trap_o <= 1'b0;
         fetch_nonseq_o <= 1'b0;
         done_o <= 1'b0;
         coproc_clk_en_o <= 1'b1;
         case (state_q)
            `CTH_ST_IDLE: begin
               coproc_data_bus_oe_o <= 1'b0;
               if (start_i) begin
                  op_q <= op_i;
                  addr_q <= base_addr_i + offset_i;
                  coproc_instr_strobe_n_o <= 1'b0;
                  catch_q <= 2'h0;
                  state_q <= `CTH_ST_CATCH;
               end
            end
            `CTH_ST_CATCH: begin
               // cover the synchroniser lag before judging the lines
               if (catch_q == `CTH_CATCH_CYC) begin
                  state_q <= `CTH_ST_WAIT;
               end else begin
                  catch_q <= catch_q + 2'h1;
               end
            end
            `CTH_ST_WAIT: begin
               if (cpa_s & cpb_s) begin
                  undef_trap_o <= 1'b1;
                  coproc_instr_strobe_n_o <= 1'b1;
                  state_q <= `CTH_ST_DONE;
               end else if (!cpb_s) begin
                  coproc_instr_strobe_n_o <= 1'b1;
                  first_q <= 1'b1;
                  if (op_q == `CTH_OP_LOAD) begin
                     mem_req_o <= 1'b1;
                     mem_write_o <= 1'b0;
                     mem_seq_o <= 1'b0;
                     mem_addr_o <= addr_q;
                     coproc_clk_en_o <= 1'b0;
                     state_q <= `CTH_ST_LDXFER;
                  end else if (op_q == `CTH_OP_STORE) begin
                     state_q <= `CTH_ST_STSTALL;
                  end else begin
                     state_q <= `CTH_ST_DONE;
                  end
               end
            end
            `CTH_ST_LDXFER: begin
               // coprocessor clocked only in the cycle a word is delivered
               coproc_clk_en_o <= mem_ack_i;
               if (mem_ack_i) begin
                  first_q <= 1'b0;
                  fast_core_clock_sel_o <= cache_hit_i;
                  coproc_data_bus_o <= mem_rdata_i;
                  coproc_data_bus_oe_o <= 1'b1;
                  base_wb_o <= first_q;
                  base_wb_data_o <= addr_q;
                  // last cycle, extra word read and dropped
                  if (last_seen) begin
                     mem_req_o <= 1'b0;
                     fetch_nonseq_o <= 1'b1;
                     state_q <= `CTH_ST_DONE;
                  end else begin
                     mem_seq_o <= 1'b1;
                     mem_addr_o <= next_word(mem_addr_o);
                  end
               end
            end
            `CTH_ST_STSTALL: begin
               mem_req_o <= 1'b1;
               mem_write_o <= 1'b1;
               mem_seq_o <= 1'b0;
               mem_addr_o <= addr_q;
               mem_wdata_o <= coproc_data_bus_i;
               base_wb_o <= 1'b1;
               base_wb_data_o <= addr_q;
               state_q <= last_seen ? `CTH_ST_STLAST : `CTH_ST_STXFER;
            end
            `CTH_ST_STXFER: begin
               if (mem_ack_i) begin
                  mem_seq_o <= 1'b1;
                  mem_addr_o <= next_word(mem_addr_o);
                  mem_wdata_o <= coproc_data_bus_i;
                  if (last_seen) begin
                     state_q <= `CTH_ST_STLAST;
                  end
               end
            end
            `CTH_ST_STLAST: begin
               coproc_clk_en_o <= 1'b0;
               if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  mem_write_o <= 1'b0;
                  fetch_nonseq_o <= 1'b1;
                  coproc_clk_en_o <= 1'b1;
                  state_q <= `CTH_ST_DONE;
               end
            end
            default: begin
               mem_req_o <= 1'b0;
               mem_seq_o <= 1'b0;
               fast_core_clock_sel_o <= 1'b0;
               coproc_data_bus_oe_o <= 1'b0;
               coproc_instr_strobe_n_o <= 1'b1;
               done_o <= 1'b1;
               state_q <= `CTH_ST_IDLE;
            end
         endcase
      end
   end
endmodule // cth_handshake

/* cth_handshake_monitor.sv */
`timescale 1ns/1ps
module cth_handshake_monitor #(
   parameter DW = 32
) (
   input wire        ref_clk_i,
   input wire        rstn_i,
   input wire        start_i,
   input wire [31:0] base_addr_i,
   input wire [31:0] offset_i,
   input wire        mem_ack_i,
   input wire        coproc_instr_strobe_n_o,
   input wire        coproc_clk_en_o,
   input wire        coproc_data_bus_oe_o,
   input wire        mem_req_o,
   input wire        mem_write_o,
   input wire        mem_seq_o,
   input wire [31:0] mem_addr_o,
   input wire        undef_trap_o,
   input wire        done_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   chk_strobe_cause: assert property ($fell(coproc_instr_strobe_n_o) |-> $past(start_i))
      else $error("strobe fell without start");
   chk_strobe_xfer: assert property (mem_req_o |-> coproc_instr_strobe_n_o)
      else $error("strobe low during transfer");
   chk_first_nonseq: assert property ($rose(mem_req_o) |-> !mem_seq_o)
      else $error("first access sequential");
   chk_addr_step: assert property ((mem_req_o && mem_ack_i) ##1 mem_req_o
      |-> mem_seq_o && mem_addr_o == $past(mem_addr_o) + 32'h4) else $error("bad address step");
   chk_first_addr: assert property ($rose(mem_req_o) |-> mem_addr_o == base_addr_i + offset_i)
      else $error("bad first address");
   chk_load_clk_hold: assert property ($rose(mem_req_o) && !mem_write_o |-> !coproc_clk_en_o)
      else $error("coproc clock not held on first load word");
   chk_trap_no_mem: assert property (undef_trap_o |-> !mem_req_o)
      else $error("memory access on trap");
   chk_store_no_drive: assert property (mem_req_o && mem_write_o |-> !coproc_data_bus_oe_o)
      else $error("bus driven during store");
   chk_done_strobe: assert property (done_o |-> coproc_instr_strobe_n_o)
      else $error("strobe low at done");
endmodule // cth_handshake_monitor
bind cth_handshake cth_handshake_monitor #(.DW(DW)) u_cth_handshake_monitor (
   .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .start_i(start_i), .base_addr_i(base_addr_i),
   .offset_i(offset_i), .mem_ack_i(mem_ack_i), .coproc_instr_strobe_n_o(coproc_instr_strobe_n_o),
   .coproc_clk_en_o(coproc_clk_en_o), .coproc_data_bus_oe_o(coproc_data_bus_oe_o),
   .mem_req_o(mem_req_o), .mem_write_o(mem_write_o), .mem_seq_o(mem_seq_o),
   .mem_addr_o(mem_addr_o), .undef_trap_o(undef_trap_o), .done_o(done_o));

/* cth_copro_model.sv */
`timescale 1ns/1ps
module cth_copro_model (
   input  wire        ref_clk_i,
   input  wire        strobe_n_i,
   input  wire        clk_en_i,
   input  wire        absent_mode_i,
   input  wire [3:0]  wait_n_i,
   input  wire [3:0]  words_i,
   output reg         absent_o,
   output reg         busy_o,
   output wire [31:0] data_o
);
   reg [3:0] wcnt_q = 4'h0;
   reg [3:0] tcnt_q = 4'h0;
   reg       xfer_q = 1'b0;
   wire [3:0] tnext = tcnt_q + ((xfer_q && clk_en_i && tcnt_q != 4'he) ? 4'h1 : 4'h0);
   initial absent_o = 1'b1;
   initial busy_o = 1'b1;
   // idle bus shows a changing pattern
   assign data_o = xfer_q ? 32'hc0de0000 + tcnt_q : ~(32'hc0de0000 + wcnt_q);
   always @(posedge ref_clk_i) begin
      if (!strobe_n_i) begin
         wcnt_q <= wcnt_q + 4'h1;
         tcnt_q <= 4'h0;
         xfer_q <= !absent_mode_i;
         absent_o <= absent_mode_i;
         busy_o <= absent_mode_i || wcnt_q < wait_n_i;
      end else begin
         wcnt_q <= 4'h0;
         tcnt_q <= tnext;
         absent_o <= !xfer_q || tnext + 4'h1 >= words_i;
         busy_o <= !xfer_q || tnext + 4'h1 >= words_i;
      end
   end
endmodule // cth_copro_model

/* cth_handshake_tb_top.sv */
`timescale 1ns/1ps
`define CMP(nm, e, g) begin n_compared = n_compared + 1; if ((e) !== (g)) begin \
   n_mismatch = n_mismatch + 1; $display("unexpected %s exp %h got %h", nm, e, g); end end
module cth_handshake_tb_top;
   reg         clk = 0, rstn = 0, start = 0, hit = 0, ack = 0, amode = 0, trapped = 0;
   reg         pend = 0, exp_h = 0;
   reg  [31:0] exp_d = 0;
   reg  [1:0]  op = 0;
   reg  [3:0]  wds = 1, wn = 0;
   reg  [31:0] base = 0, ofs = 0, rdata = 0;
   wire        ab, bs, sn, ce, oe, rq, wr, sq, fc, wb, tr, fn, dn;
   wire [31:0] cpo, cpi, ad, wd, wbd;
   integer     seed = 6, n_mismatch = 0, n_compared = 0, beats = 0, k;
   always #4 clk = ~clk;
   cth_handshake u_cth_handshake (.ref_clk_i(clk), .rstn_i(rstn), .start_i(start), .op_i(op),
      .base_addr_i(base), .offset_i(ofs), .cache_hit_i(hit), .mem_ack_i(ack),
      .mem_rdata_i(rdata), .coproc_absent_line_i(ab), .coproc_busy_line_i(bs),
      .coproc_data_bus_i(cpi), .coproc_instr_strobe_n_o(sn), .coproc_clk_en_o(ce),
      .coproc_data_bus_o(cpo), .coproc_data_bus_oe_o(oe), .mem_req_o(rq), .mem_write_o(wr),
      .mem_seq_o(sq), .mem_addr_o(ad), .mem_wdata_o(wd), .fast_core_clock_sel_o(fc),
      .base_wb_o(wb), .base_wb_data_o(wbd), .undef_trap_o(tr), .fetch_nonseq_o(fn), .done_o(dn));
   cth_copro_model u_cth_copro_model (.ref_clk_i(clk), .strobe_n_i(sn), .clk_en_i(ce),
      .absent_mode_i(amode), .wait_n_i(wn), .words_i(wds), .absent_o(ab), .busy_o(bs),
      .data_o(cpi));
   always @(posedge clk) begin
      if (rstn && tr) trapped = 1;
      if (rstn && pend) begin
         `CMP("cpdata", exp_d, cpo)
         `CMP("fastclk", exp_h, fc)
      end
      pend = rstn && rq && ack && !wr;
      exp_d = rdata;
      exp_h = hit;
      if (rstn && rq && ack) begin
         `CMP("addr", base + ofs + 4 * beats, ad)
         `CMP("write", op == 2'h2, wr)
         if (wr) `CMP("wdata", 32'hc0de0000 + beats, wd)
         beats = beats + 1;
      end
      #1 ack = 1'b1;
      rdata = $random(seed);
      hit = $random(seed);
   end
   task wrap_up;
      begin
         $display("compared %0d mismatches %0d", n_compared, n_mismatch);
         if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   task run(input [1:0] o, input [3:0] mm, input [3:0] wt, input am);
      integer i;
      begin
         op = o; wn = wt; amode = am; beats = 0; trapped = 0; start = 1;
         wds = (o == 2'h2 && mm < 4'h2) ? 4'h2 : mm;
         base = $random(seed) & 32'hfffffffc;
         ofs = $random(seed) & 32'h000000fc;
         @(posedge clk);
         #1 start = 0;
         i = 0;
         while (i < 300 && dn !== 1'b1) begin
            @(posedge clk);
            #1 i = i + 1;
         end
         if (i == 300) begin n_mismatch = n_mismatch + 1; wrap_up; end
         `CMP("beats", am ? 0 : o == 2'h1 ? mm + 1 : o == 2'h2 ? wds : 0, beats)
         `CMP("trap", am, trapped)
      end
   endtask
   initial begin
      repeat (8) @(posedge clk);
      #1 rstn = 1;
      for (k = 0; k < 12; k = k + 1)
         run(k % 3, 4'h1 + {$random(seed)} % 4, {$random(seed)} % 4, k == 11);
      wrap_up;
   end
endmodule // cth_handshake_tb_top
